// ===== include/hpm_pkg.sv
/*
 Shared constants and types for the host parallel memory port.
 Assumes a single 200 MHz clock domain and a host that times each cycle with its own strobes.
*/
// Functional notes
// - A read starts only when select, data strobe and read strobe or direction are all active.
// - A write starts only when select, data strobe and write strobe or direction are active.
// - Multiplexed mode captures the address from the shared lines on the latch strobe.
// - Multiplexed data uses shared lines only; byte mode bits 7:0, word mode 15:0.
// - On a read the addressed word, or in byte mode the addressed byte, is driven onto the data lines.
// - Write data is valid when the data strobe asserts; device takes it when the last of select, data strobe and write strobe or direction goes active.
// - Width pin low selects 32K x 16 words, high selects 64K x 8 bytes.
// - Byte mode 0x00-0x3F and word mode 0x00-0x1F decode to registers, rest SRAM.
// - Bus style pin high selects separate lines, low multiplexed with latch strobe.
package hpm_pkg;

    // ----------------------------------------------------------------
    // Sizes and decode limits
    // ----------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int WIDX_W = 15;
    localparam int RIDX_W = 5;
    localparam int MEM_WORDS = 32768;
    localparam int REG_WORDS = 32;
    localparam logic [15:0] BYTE_REG_END = 16'h003f;
    localparam logic [15:0] WORD_REG_END = 16'h001f;
    localparam logic [15:0] WORD_MEM_END = 16'h7fff;

    // ----------------------------------------------------------------
    // Pin synchroniser layout and idle values
    // ----------------------------------------------------------------
    localparam int SYNC_W = 40;
    // Strobes idle high, latch strobe high, configuration low, buses low
    localparam logic [39:0] SYNC_RST = {5'h1f, 3'h0, 16'h0000, 16'h0000};

    // ----------------------------------------------------------------
    // Reset and drive values of outputs
    // ----------------------------------------------------------------
    localparam logic [15:0] BUS_RST = 16'h0000;
    localparam logic [15:0] OE_OFF = 16'h0000;
    localparam logic [7:0] LANE_ON = 8'hff;

    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} hpm_state_t;

endpackage

// ===== src/hpm_sync.sv
/*
 Two-flop synchroniser for a vector of host pins.
 Assumes each bit is sampled independently; buses are qualified by strobes that settle later.
*/
`timescale 1ns/100ps
module hpm_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_q;

    if (W < 1) begin : g_bad_width
        $error("hpm_sync: width must be at least one");
    end

    // First stage feeds only the second stage
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_q <= RST_VAL;
            o_q <= RST_VAL;
        end else begin
            meta_q <= i_d;
            o_q <= meta_q;
        end
    end
endmodule // hpm_sync

// ===== src/hpm_port.sv
/*
 Host parallel memory port: strobe-timed access to 32 internal registers and 32K x 16 SRAM.
 Assumes host pins are asynchronous and stay stable for several clocks around each strobe edge.
*/
`timescale 1ns/100ps
module hpm_port (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_cs_n,
    input wire logic i_data_strobe_n,
    input wire logic i_rd_n,
    input wire logic i_wr_rw,
    input wire logic i_ale,
    input wire logic i_width_config_pin,
    input wire logic i_bus_style_config_pin,
    input wire logic i_strobe_style_pin,
    input wire logic [15:0] i_addr,
    input wire logic [15:0] i_shared_bus,
    output logic [15:0] o_shared_bus,
    output logic [15:0] o_shared_bus_oe,
    output logic o_busy,
    output logic o_wr_done
);
    // ----------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------
    logic [hpm_pkg::SYNC_W-1:0] raw_pins;
    logic [hpm_pkg::SYNC_W-1:0] syn;

    assign raw_pins = {i_cs_n, i_data_strobe_n, i_rd_n, i_wr_rw, i_ale, i_width_config_pin,
                       i_bus_style_config_pin, i_strobe_style_pin, i_addr, i_shared_bus};

    hpm_sync #(.W(hpm_pkg::SYNC_W), .RST_VAL(hpm_pkg::SYNC_RST)) hpm_sync_inst (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_d(raw_pins),
        .o_q(syn)
    );

    wire cs_n_s = syn[39];
    wire data_strobe_n_s = syn[38];
    wire rd_n_s = syn[37];
    wire wr_rw_s = syn[36];
    wire ale_s = syn[35];
    wire byte_mode = syn[34];
    wire separate = syn[33];
    wire dir_style = syn[32];
    wire [15:0] addr_s = syn[31:16];
    wire [15:0] bus_s = syn[15:0];

    // ----------------------------------------------------------------
    // Cycle qualification
    // ----------------------------------------------------------------
    hpm_pkg::hpm_state_t state_q, state_d;
    logic [15:0] addr_q;
    logic [14:0] widx_q;
    logic [1:0] lane_q;
    logic reg_q;
    logic byte_q;
    logic [15:0] wdata_q;

    // Cycle starts on whichever of the three strobes goes active last
    wire sel = !cs_n_s && !data_strobe_n_s;
    wire read_req = dir_style ? wr_rw_s : !rd_n_s;
    wire write_req = dir_style ? !wr_rw_s : !wr_rw_s;
    wire rd_go = sel && read_req;
    wire wr_go = sel && write_req && !read_req;
    wire idle = (state_q == hpm_pkg::ST_IDLE);
    wire commit = (state_q == hpm_pkg::ST_WRITE) && !sel;

    // Latch strobe only matters on multiplexed lines; separate lines ignore it
    wire [15:0] addr_now = separate ? addr_s : (ale_s ? bus_s : addr_q);
    wire [15:0] a_use = idle ? addr_now : addr_q;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    // Top address bit is left out of the word index in word mode; the host keeps it low
    wire [14:0] widx = byte_mode ? a_use[15:1] : a_use[14:0];
    wire reg_hit = a_use <= (byte_mode ? hpm_pkg::BYTE_REG_END : hpm_pkg::WORD_REG_END);
    wire [4:0] ridx = widx[4:0];
    wire [1:0] lane_en = byte_mode ? {a_use[0], !a_use[0]} : 2'h3;
    wire [15:0] wdata_lanes = byte_mode ? {bus_s[7:0], bus_s[7:0]} : bus_s;

    logic [15:0] rd_word;
    wire [7:0] rd_byte = a_use[0] ? rd_word[15:8] : rd_word[7:0];
    wire [15:0] rd_out = byte_mode ? {8'h00, rd_byte} : rd_word;
    wire [15:0] oe_read = {(byte_mode ? 8'h00 : hpm_pkg::LANE_ON), hpm_pkg::LANE_ON};

    // ----------------------------------------------------------------
    // Storage, one byte lane per loop pass
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_lane
            logic [7:0] sram [0:hpm_pkg::MEM_WORDS-1];
            logic [7:0] regs [0:hpm_pkg::REG_WORDS-1];

            assign rd_word[8*g +: 8] = reg_hit ? regs[ridx] : sram[widx];

            // Write lands when the host closes the cycle, not when it opens it
            always_ff @(posedge i_clk) begin
                if (commit && lane_q[g] && reg_q) begin
                    regs[widx_q[4:0]] <= wdata_q[8*g +: 8];
                end
                if (commit && lane_q[g] && !reg_q) begin
                    sram[widx_q] <= wdata_q[8*g +: 8];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Cycle state machine
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            hpm_pkg::ST_IDLE: begin
                if (rd_go) begin
                    state_d = hpm_pkg::ST_READ;
                end else if (wr_go) begin
                    state_d = hpm_pkg::ST_WRITE;
                end
            end
            hpm_pkg::ST_READ, hpm_pkg::ST_WRITE: begin
                if (!sel) begin
                    state_d = hpm_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = hpm_pkg::ST_IDLE;
            end
        endcase
    end

    wire start = idle && (state_d != hpm_pkg::ST_IDLE);
    wire read_start = idle && (state_d == hpm_pkg::ST_READ);

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q <= hpm_pkg::ST_IDLE;
            addr_q <= 16'h0000;
        end else begin
            state_q <= state_d;
            if (idle) begin
                addr_q <= addr_now;
            end
        end
    end

    // Access details are frozen at the start so late pin changes cannot retarget it
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            widx_q <= 15'h0000;
            lane_q <= 2'h0;
            reg_q <= 1'b0;
            byte_q <= 1'b0;
            wdata_q <= 16'h0000;
        end else if (start) begin
            widx_q <= widx;
            lane_q <= lane_en;
            reg_q <= reg_hit;
            byte_q <= byte_mode;
            wdata_q <= wdata_lanes;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_shared_bus <= hpm_pkg::BUS_RST;
            o_shared_bus_oe <= hpm_pkg::OE_OFF;
            o_busy <= 1'b0;
            o_wr_done <= 1'b0;
        end else begin
            o_busy <= (state_d != hpm_pkg::ST_IDLE);
            o_wr_done <= commit;
            if (read_start) begin
                o_shared_bus <= rd_out;
                o_shared_bus_oe <= oe_read;
            end else if (state_d != hpm_pkg::ST_READ) begin
                o_shared_bus_oe <= hpm_pkg::OE_OFF;
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    a_read_needs_strobes: assert property (
        (idle && !(sel && read_req)) |=> state_q != hpm_pkg::ST_READ)
        else $error("read started without all strobes");
    a_write_needs_strobes: assert property (
        (idle && !(sel && write_req)) |=> state_q != hpm_pkg::ST_WRITE)
        else $error("write started without all strobes");
    a_addr_held: assert property (
        (!idle ##1 !idle) |-> $stable(addr_q))
        else $error("address moved during a cycle");
    a_mux_capture: assert property (
        (idle && !separate && ale_s) |=> addr_q == $past(bus_s))
        else $error("multiplexed address not latched");
    a_byte_lane_only: assert property (
        (state_q == hpm_pkg::ST_READ && byte_q) |-> (o_shared_bus_oe[15:8] == 8'h00 && o_shared_bus[15:8] == 8'h00))
        else $error("byte mode drove upper lane");
    a_width_lane: assert property (
        (start && byte_mode) |=> $onehot(lane_q))
        else $error("byte mode wrote more than one lane");
    a_read_drives: assert property (
        read_start |=> (o_shared_bus_oe[7:0] == 8'hff && o_busy))
        else $error("read did not drive data");
    a_write_data_taken: assert property (
        (start && !read_start && !byte_mode) |=> wdata_q == $past(bus_s))
        else $error("write data not taken at strobe");
    a_reg_decode: assert property (
        (start && byte_mode && a_use == 16'h0040) |=> !reg_q)
        else $error("register window decode wrong");
    a_release_idle: assert property (
        (o_shared_bus_oe != hpm_pkg::OE_OFF) |-> state_q == hpm_pkg::ST_READ)
        else $error("data lines driven outside a read");
    a_end_on_release: assert property (
        (state_q == hpm_pkg::ST_WRITE && !sel) |=> (idle && o_wr_done) ##1 !o_wr_done)
        else $error("write cycle did not complete");

    c_read: cover property (read_start ##[1:20] idle);
    c_write: cover property (start && !read_start ##[1:20] o_wr_done);
    c_byte_write: cover property (commit && byte_q);
    c_mux_read: cover property (read_start && !separate);
endmodule // hpm_port

// ===== tb/hpm_host.sv
/*
 Behavioural host processor driving the parallel port pins.
 Assumes the bench resolves the shared bus and owns the configuration pins.
*/
`timescale 1ns/100ps
module hpm_host (
    input wire logic i_clk,
    input wire logic i_width_config_pin,
    input wire logic i_bus_style_config_pin,
    input wire logic i_strobe_style_pin,
    input wire logic i_busy,
    input wire logic i_wr_done,
    input wire logic [15:0] i_bus,
    output logic o_cs_n,
    output logic o_data_strobe_n,
    output logic o_rd_n,
    output logic o_wr_rw,
    output logic o_ale,
    output logic [15:0] o_addr,
    output logic [15:0] o_bus,
    output logic [15:0] o_bus_oe
);
    initial begin
        {o_cs_n, o_data_strobe_n, o_rd_n, o_wr_rw, o_ale} = 5'h1f;
        {o_addr, o_bus, o_bus_oe} = '0;
    end

    // ----------------------------------------------------------------
    // One host cycle: op 0 read, 1 write, 2 select and strobe only
    // ----------------------------------------------------------------
    task automatic access(input logic [1:0] op, input logic [15:0] a, input logic [15:0] d,
                          output logic [15:0] q, output logic busy_seen, output logic done_seen);
        int n;
        busy_seen = 1'b0;
        done_seen = 1'b0;
        @(negedge i_clk);
        if (!i_bus_style_config_pin) begin
            o_addr = 16'hffff;
            o_bus = a;
            o_bus_oe = 16'hffff;
            o_ale = 1'b1;
            repeat (4) @(negedge i_clk);
            o_ale = 1'b0;
            o_bus_oe = 16'h0000;
            @(negedge i_clk);
        end else begin
            o_ale = 1'b1;
            o_addr = i_width_config_pin ? a : {1'b0, a[14:0]};
        end
        // Write data settles a cycle before the strobe falls
        o_bus = d;
        o_bus_oe = (op == 2'd1) ? 16'hffff : 16'h0000;
        @(negedge i_clk);
        o_cs_n = 1'b0;
        o_data_strobe_n = 1'b0;
        if (i_strobe_style_pin) o_wr_rw = (op != 2'd1);
        else if (op == 2'd0) o_rd_n = 1'b0;
        else if (op == 2'd1) o_wr_rw = 1'b0;
        for (n = 0; n < 8 && !busy_seen; n++) begin
            @(negedge i_clk);
            busy_seen = i_busy;
        end
        repeat (2) @(negedge i_clk);
        q = i_bus;
        {o_cs_n, o_data_strobe_n, o_rd_n, o_wr_rw} = 4'hf;
        for (n = 0; n < 8 && !done_seen; n++) begin
            @(negedge i_clk);
            done_seen = i_wr_done;
        end
        o_bus_oe = 16'h0000;
        repeat (2) @(negedge i_clk);
    endtask
endmodule // hpm_host

// ===== tb/tb_hpm_port.sv
/*
 Self-checking bench for the host parallel memory port.
 Assumes pull-ups on undriven shared bus lines with separate lines, pull-downs when multiplexed.
*/
`timescale 1ns/100ps
module tb_hpm_port;
    logic clk = 1'b0, rstn = 1'b0, width = 1'b0, style = 1'b1, strobe = 1'b0;
    logic cs_n, data_strobe_n, rd_n, wr_rw, ale, busy, wr_done;
    logic [15:0] addr, host_q, host_oe, dut_q, dut_oe;
    wire [15:0] bus;
    int err_count = 0, num_checks = 0, cycles = 0;

    // Undriven lines settle to the board's pull level: up for separate lines, down when multiplexed
    wire [15:0] pull = style ? 16'hffff : 16'h0000;
    assign bus = (dut_oe & dut_q) | (~dut_oe & host_oe & host_q) | (~dut_oe & ~host_oe & pull);
    always #2.5 clk = ~clk;

    hpm_port hpm_port_inst (.i_clk(clk), .i_rstn(rstn), .i_cs_n(cs_n), .i_data_strobe_n(data_strobe_n),
        .i_rd_n(rd_n), .i_wr_rw(wr_rw), .i_ale(ale), .i_width_config_pin(width),
        .i_bus_style_config_pin(style), .i_strobe_style_pin(strobe), .i_addr(addr),
        .i_shared_bus(bus), .o_shared_bus(dut_q), .o_shared_bus_oe(dut_oe), .o_busy(busy),
        .o_wr_done(wr_done));
    hpm_host hpm_host_inst (.i_clk(clk), .i_width_config_pin(width), .i_bus_style_config_pin(style),
        .i_strobe_style_pin(strobe), .i_busy(busy), .i_wr_done(wr_done), .i_bus(bus), .o_cs_n(cs_n),
        .o_data_strobe_n(data_strobe_n), .o_rd_n(rd_n), .o_wr_rw(wr_rw), .o_ale(ale), .o_addr(addr),
        .o_bus(host_q), .o_bus_oe(host_oe));

    // ----------------------------------------------------------------
    // Checking and closing
    // ----------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        if (err_count == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    always @(negedge clk) if (rstn) chk("contention", dut_oe & host_oe, 16'h0000);
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            final_report();
        end
    end

    // ----------------------------------------------------------------
    // Shared steps
    // ----------------------------------------------------------------
    task automatic xfer(input logic [1:0] op, input logic [15:0] a, input logic [15:0] d);
        logic [15:0] q;
        logic b, w;
        hpm_host_inst.access(op, a, d, q, b, w);
        chk("busy", {15'h0, b}, {15'h0, op != 2'd2});
        if (op == 2'd1) chk("wr_done", {15'h0, w}, 16'h0001);
        else chk("no wr_done", {15'h0, w}, 16'h0000);
        if (op == 2'd0) chk("read data", q, d);
    endtask

    task automatic set_cfg(input logic w, input logic s, input logic t);
        @(negedge clk);
        {width, style, strobe} = {w, s, t};
        repeat (4) @(negedge clk);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_word_sep();
        set_cfg(1'b0, 1'b1, 1'b0);
        xfer(2'd1, 16'h0005, 16'ha1b2);
        xfer(2'd1, 16'h1234, 16'h5a5a);
        xfer(2'd1, 16'h001f, 16'h1122);
        xfer(2'd0, 16'h0005, 16'ha1b2);
        xfer(2'd0, 16'h1234, 16'h5a5a);
    endtask

    task automatic t_byte();
        set_cfg(1'b1, 1'b1, 1'b0);
        xfer(2'd1, 16'h0040, 16'h00a5);
        xfer(2'd1, 16'h0041, 16'h003c);
        xfer(2'd1, 16'h003f, 16'h0077);
        xfer(2'd0, 16'h0041, 16'hff3c);
        set_cfg(1'b0, 1'b1, 1'b0);
        xfer(2'd0, 16'h0020, 16'h3ca5);
        xfer(2'd0, 16'h001f, 16'h7722);
    endtask

    task automatic t_dir();
        set_cfg(1'b0, 1'b1, 1'b1);
        xfer(2'd1, 16'h0300, 16'h0f0f);
        xfer(2'd0, 16'h0300, 16'h0f0f);
    endtask

    task automatic t_mux();
        set_cfg(1'b0, 1'b0, 1'b0);
        xfer(2'd1, 16'h0100, 16'hbeef);
        xfer(2'd0, 16'h0100, 16'hbeef);
        set_cfg(1'b1, 1'b0, 1'b0);
        xfer(2'd0, 16'h0040, 16'h00a5);
    endtask

    task automatic t_no_dir();
        set_cfg(1'b0, 1'b1, 1'b0);
        xfer(2'd2, 16'h0005, 16'h0000);
    endtask

    initial begin
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        t_word_sep();
        t_byte();
        t_dir();
        t_mux();
        t_no_dir();
        final_report();
    end
endmodule // tb_hpm_port
